// *** hbrg_pkg.sv ***
// Functional notes
// - base changes only after full ordered key sequence
// - key one 0x40 to interrupt select opens
// - first base write is held, not applied
// - key two 0x80 to interrupt select arms
// - second base write relocates all decoding if it repeats the first
// - host first writes 0x00 to hold core
// - host may skip hold if still reset
// - 0x10 to control opens code RAM, core held
// - relocation clears interrupt selection; host rewrites
// - soft base kept until hardware reset
// - any segment value with low two bits zero is a usable base
// - base bits 7:2 map address 19:14, low zero
// - hardware reset loads base from four straps
package hbrg_pkg;
   // host-visible register offsets relative to base
   localparam logic [13:0] HBRG_OFS_CTRL = 14'h0000;
   localparam logic [13:0] HBRG_OFS_IRQ = 14'h0001;
   localparam logic [13:0] HBRG_OFS_SEG = 14'h0002;
   // key and command values
   localparam logic [7:0] HBRG_KEY_OPEN = 8'h40;
   localparam logic [7:0] HBRG_KEY_ARM = 8'h80;
   localparam logic [7:0] HBRG_CTRL_HOLD = 8'h00;
   localparam logic [7:0] HBRG_CTRL_CODE = 8'h10;
   localparam logic [7:0] HBRG_ZERO = 8'h00;
   localparam logic [1:0] HBRG_SEG_LOW = 2'h0;
   localparam int HBRG_SEG_LSB = 2;
   // controller APB registers (byte addresses)
   localparam logic [7:0] HBRG_APB_CMD = 8'h00;
   localparam logic [7:0] HBRG_APB_STAT = 8'h04;
   localparam logic [7:0] HBRG_APB_RDATA = 8'h08;
   // command word fields
   localparam int HBRG_CMD_GO = 31;
   localparam int HBRG_CMD_RELOC = 30;
   localparam int HBRG_CMD_WR = 29;
   // strap to segment table, 16 entries
   localparam logic [7:0] HBRG_STRAP_SEG [16] = '{
      8'hC8, 8'hCC, 8'hD0, 8'hD4, 8'hD8, 8'hDC, 8'hE0, 8'hE4,
      8'hE8, 8'hEC, 8'hA8, 8'hAC, 8'hB0, 8'hB4, 8'hBC, 8'hC0};
   // sequence states
   typedef enum logic [2:0] {
      HBRG_IDLE = 3'b001,
      HBRG_OPENED = 3'b010,
      HBRG_ARMED = 3'b100
   } hbrg_seq_t;
   // controller states
   typedef enum logic [2:0] {
      HBRG_C_IDLE = 3'b001,
      HBRG_C_BUS = 3'b010,
      HBRG_C_DONE = 3'b100
   } hbrg_ctl_t;
endpackage

// *** hbrg_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// host memory bus between controller and device
interface hbrg_if;
   logic [19:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic wr;
   logic rd;
   modport host (output addr, wdata, wr, rd, input rdata);
   modport dev (input addr, wdata, wr, rd, output rdata);
endinterface
`default_nettype wire

// *** hbrg_dev.sv ***
`timescale 1ns/1ns
`default_nettype none
module hbrg_dev (
   // clock and bus reset
   input wire logic I_CLK,
   input wire logic I_RST_B,
   // host bus
   hbrg_if.dev bus,
   // straps
   input wire logic [3:0] I_SEGMENT_STRAP,
   // status toward device core
   output logic O_CORE_HOLD,
   output logic O_CODE_ACCESS,
   output logic [7:0] O_IRQ_SEL,
   output logic [7:0] O_BASE
);
   hbrg_pkg::hbrg_seq_t seq;
   logic [7:0] base;
   logic [7:0] pend;
   logic [7:0] ctrl;
   logic [7:0] irq;
   logic [7:0] rdata;
   logic [3:0] s1, s2, s3;
   logic boot;
   logic pend_ok;
   ////////////////////////////////////////////////////////////////
   // address decode at current base
   wire hit = bus.addr[19:14] == base[7:hbrg_pkg::HBRG_SEG_LSB];
   wire [13:0] ofs = bus.addr[13:0];
   wire w_ctrl = hit && bus.wr && ofs == hbrg_pkg::HBRG_OFS_CTRL;
   wire w_irq = hit && bus.wr && ofs == hbrg_pkg::HBRG_OFS_IRQ;
   wire w_seg = hit && bus.wr && ofs == hbrg_pkg::HBRG_OFS_SEG;
   wire k_open = w_irq && bus.wdata == hbrg_pkg::HBRG_KEY_OPEN;
   wire k_arm = w_irq && bus.wdata == hbrg_pkg::HBRG_KEY_ARM;
   wire [7:0] seg_in = {bus.wdata[7:2], hbrg_pkg::HBRG_SEG_LOW};
   wire confirm = seq == hbrg_pkg::HBRG_ARMED && w_seg
      && seg_in == pend;
   ////////////////////////////////////////////////////////////////
   // straps are off-domain pins: three flops, take when 2 and 3 agree
   always_ff @(posedge I_CLK) begin
      s1 <= I_SEGMENT_STRAP;
      s2 <= s1;
      s3 <= s2;
   end
   ////////////////////////////////////////////////////////////////
   // key sequence; any other register write drops it
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         seq <= hbrg_pkg::HBRG_IDLE;
         pend <= hbrg_pkg::HBRG_ZERO;
      end else if (k_open) begin
         seq <= hbrg_pkg::HBRG_OPENED;
      end else if (seq == hbrg_pkg::HBRG_OPENED && w_seg && !pend_ok) begin
         // a second proposal before key two falls through and abandons
         pend <= seg_in;
         seq <= hbrg_pkg::HBRG_OPENED;
      end else if (seq == hbrg_pkg::HBRG_OPENED && k_arm && pend_ok) begin
         seq <= hbrg_pkg::HBRG_ARMED;
      end else if (w_ctrl || w_irq || w_seg) begin
         seq <= hbrg_pkg::HBRG_IDLE;
      end
   end
   // base must have been proposed before arming
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B || k_open)
         pend_ok <= 1'b0;
      else if (seq == hbrg_pkg::HBRG_OPENED && w_seg)
         pend_ok <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////
   // base: strap load after reset release, relocation on confirm
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         boot <= 1'b1;
         base <= hbrg_pkg::HBRG_ZERO;
      end else if (boot && s2 == s3) begin
         boot <= 1'b0;
         base <= hbrg_pkg::HBRG_STRAP_SEG[s3];
      end else if (confirm) begin
         base <= pend;
      end
   end
   ////////////////////////////////////////////////////////////////
   // control and interrupt select; core held from reset
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         ctrl <= hbrg_pkg::HBRG_CTRL_HOLD;
         irq <= hbrg_pkg::HBRG_ZERO;
      end else begin
         if (w_ctrl)
            ctrl <= bus.wdata;
         if (confirm)
            irq <= hbrg_pkg::HBRG_ZERO;
         else if (w_irq && !k_open && !k_arm)
            irq <= bus.wdata;
      end
   end
   ////////////////////////////////////////////////////////////////
   // read data and registered outputs
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         rdata <= hbrg_pkg::HBRG_ZERO;
         O_CORE_HOLD <= 1'b1;
         O_CODE_ACCESS <= 1'b0;
         O_IRQ_SEL <= hbrg_pkg::HBRG_ZERO;
         O_BASE <= hbrg_pkg::HBRG_ZERO;
      end else begin
         rdata <= !(hit && bus.rd) ? hbrg_pkg::HBRG_ZERO
            : ofs == hbrg_pkg::HBRG_OFS_CTRL ? ctrl
            : ofs == hbrg_pkg::HBRG_OFS_IRQ ? irq
            : ofs == hbrg_pkg::HBRG_OFS_SEG ? base
            : hbrg_pkg::HBRG_ZERO;
         // only the code-access value keeps the core held with RAM open
         O_CORE_HOLD <= ctrl == hbrg_pkg::HBRG_CTRL_HOLD
            || ctrl == hbrg_pkg::HBRG_CTRL_CODE;
         O_CODE_ACCESS <= ctrl == hbrg_pkg::HBRG_CTRL_CODE;
         O_IRQ_SEL <= irq;
         O_BASE <= base;
      end
   end
   assign bus.rdata = rdata;
endmodule
`default_nettype wire

// *** hbrg_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module hbrg_host (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_B,
   // apb slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // host bus
   hbrg_if.host bus
);
   hbrg_pkg::hbrg_ctl_t st;
   logic [2:0] step;
   logic [7:0] base, newb, data;
   logic [13:0] ofs;
   logic reloc, wr, done_rd;
   logic [7:0] rd_cap;
   logic [19:0] addr;
   logic [7:0] wdata;
   logic bwr, brd;
   ////////////////////////////////////////////////////////////////
   // apb decode
   wire acc = I_PSEL && I_PENABLE;
   wire go = acc && I_PWRITE && I_PADDR == hbrg_pkg::HBRG_APB_CMD
      && I_PWDATA[hbrg_pkg::HBRG_CMD_GO] && st == hbrg_pkg::HBRG_C_IDLE;
   wire bad = I_PADDR != hbrg_pkg::HBRG_APB_CMD
      && I_PADDR != hbrg_pkg::HBRG_APB_STAT
      && I_PADDR != hbrg_pkg::HBRG_APB_RDATA;
   // relocation steps 0..5: offset and value per step
   wire [13:0] s_ofs = (step == 3'd0 || step == 3'd5)
      ? hbrg_pkg::HBRG_OFS_CTRL
      : (step == 3'd1 || step == 3'd3) ? hbrg_pkg::HBRG_OFS_IRQ
      : hbrg_pkg::HBRG_OFS_SEG;
   wire [7:0] s_val = step == 3'd0 ? hbrg_pkg::HBRG_CTRL_HOLD
      : step == 3'd1 ? hbrg_pkg::HBRG_KEY_OPEN
      : step == 3'd3 ? hbrg_pkg::HBRG_KEY_ARM
      : step == 3'd5 ? hbrg_pkg::HBRG_CTRL_CODE
      : {newb[7:2], hbrg_pkg::HBRG_SEG_LOW};
   wire [7:0] s_base = step == 3'd5 ? newb : base;
   ////////////////////////////////////////////////////////////////
   // sequencer: one bus cycle per step, strictly in order
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         st <= hbrg_pkg::HBRG_C_IDLE;
         step <= 3'd0;
         reloc <= 1'b0;
         wr <= 1'b0;
         ofs <= hbrg_pkg::HBRG_OFS_CTRL;
         data <= hbrg_pkg::HBRG_ZERO;
         newb <= hbrg_pkg::HBRG_ZERO;
         bwr <= 1'b0;
         brd <= 1'b0;
         addr <= 20'h00000;
         wdata <= hbrg_pkg::HBRG_ZERO;
      end else begin
         unique case (st)
            hbrg_pkg::HBRG_C_IDLE: begin
               bwr <= 1'b0;
               brd <= 1'b0;
               if (go) begin
                  reloc <= I_PWDATA[hbrg_pkg::HBRG_CMD_RELOC];
                  wr <= I_PWDATA[hbrg_pkg::HBRG_CMD_WR];
                  ofs <= I_PWDATA[21:8];
                  data <= I_PWDATA[7:0];
                  newb <= I_PWDATA[7:0];
                  step <= 3'd0;
                  st <= hbrg_pkg::HBRG_C_BUS;
               end
            end
            hbrg_pkg::HBRG_C_BUS: begin
               // each step is its own write at the then-current base
               addr <= reloc ? {s_base[7:2], s_ofs} : {base[7:2], ofs};
               wdata <= reloc ? s_val : data;
               bwr <= reloc || wr;
               brd <= !reloc && !wr;
               st <= hbrg_pkg::HBRG_C_DONE;
            end
            hbrg_pkg::HBRG_C_DONE: begin
               bwr <= 1'b0;
               brd <= 1'b0;
               if (reloc && step != 3'd5) begin
                  step <= step + 3'd1;
                  st <= hbrg_pkg::HBRG_C_BUS;
               end else begin
                  st <= hbrg_pkg::HBRG_C_IDLE;
               end
            end
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////
   // tracked base and read capture; interrupt select lost on relocate
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         base <= hbrg_pkg::HBRG_ZERO;
         rd_cap <= hbrg_pkg::HBRG_ZERO;
         done_rd <= 1'b0;
      end else begin
         if (acc && I_PWRITE && I_PADDR == hbrg_pkg::HBRG_APB_STAT)
            base <= I_PWDATA[7:0]; // software tells strap base
         else if (st == hbrg_pkg::HBRG_C_DONE && reloc && step == 3'd5)
            base <= newb; // host must reselect irq afterwards
         // the device registers its answer; rd_cap takes bus.rdata one edge after the device samples the read
         done_rd <= st == hbrg_pkg::HBRG_C_DONE && !reloc && !wr;
         if (done_rd)
            rd_cap <= bus.rdata;
      end
   end
   ////////////////////////////////////////////////////////////////
   // apb answer: always ready one access cycle
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         O_PRDATA <= 32'h00000000;
         O_PREADY <= 1'b0;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY <= I_PSEL && !I_PENABLE;
         O_PSLVERR <= I_PSEL && !I_PENABLE && bad;
         O_PRDATA <= I_PADDR == hbrg_pkg::HBRG_APB_STAT
            ? {23'h000000, st != hbrg_pkg::HBRG_C_IDLE || done_rd, base}
            : I_PADDR == hbrg_pkg::HBRG_APB_RDATA
            ? {24'h000000, rd_cap} : 32'h00000000;
      end
   end
   assign bus.addr = addr;
   assign bus.wdata = wdata;
   assign bus.wr = bwr;
   assign bus.rd = brd;
endmodule
`default_nettype wire

// *** hbrg_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module hbrg_monitor (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_B,
   // host bus
   input wire logic [19:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   // device side
   input wire logic [3:0] i_strap,
   input wire logic [7:0] i_base,
   input wire logic [7:0] i_irq_sel,
   input wire logic i_code_access,
   input wire logic i_core_hold
);
   logic [3:0] since_rst;
   // decode against the published base; writes are two cycles apart,
   // so its one cycle lag behind the live base never matters
   wire logic hit = i_wr && (i_addr[19:14] == i_base[7:2]);
   wire logic [13:0] ofs = i_addr[13:0];
   wire logic w_ctrl = hit && (ofs == hbrg_pkg::HBRG_OFS_CTRL);
   wire logic w_irq = hit && (ofs == hbrg_pkg::HBRG_OFS_IRQ);
   wire logic w_seg = hit && (ofs == hbrg_pkg::HBRG_OFS_SEG);
   wire logic key = (i_wdata == hbrg_pkg::HBRG_KEY_OPEN)
      || (i_wdata == hbrg_pkg::HBRG_KEY_ARM);
   // strap load lands a few edges after reset; ignore base moves until then
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         since_rst <= 4'h0;
      end else if (since_rst != 4'hF) begin
         since_rst <= since_rst + 4'h1;
      end
   end
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   ////////////////////////////////////////////////////////////////////////
   // a write sampled at one edge shows on the registered outputs at the
   // sample two edges later, hence the ##2 and the depth-2 pasts below
   property p_low_zero;
      i_base[1:0] == hbrg_pkg::HBRG_SEG_LOW;
   endproperty
   property p_strap;
      $rose(I_RST_B) |-> ##[1:8]
         (i_base == hbrg_pkg::HBRG_STRAP_SEG[i_strap]);
   endproperty
   property p_cause;
      (since_rst == 4'hF) && $changed(i_base) |->
         $past(i_wr, 2) && ($past(ofs, 2) == hbrg_pkg::HBRG_OFS_SEG)
         && ($past(i_addr[19:14], 2) == $past(i_base[7:2], 2))
         && (i_base == {$past(i_wdata[7:2], 2),
            hbrg_pkg::HBRG_SEG_LOW});
   endproperty
   property p_irq_clr;
      (since_rst == 4'hF) && $changed(i_base) |->
         i_irq_sel == hbrg_pkg::HBRG_ZERO;
   endproperty
   property p_key_keep;
      w_irq && key |-> ##2 $stable(i_irq_sel);
   endproperty
   property p_irq_set;
      w_irq && !key |-> ##2 (i_irq_sel == $past(i_wdata, 2));
   endproperty
   property p_code;
      w_ctrl && (i_wdata == hbrg_pkg::HBRG_CTRL_CODE) |-> ##2
         (i_code_access && i_core_hold);
   endproperty
   property p_pulse;
      i_wr |=> !i_wr;
   endproperty
   property p_first;
      w_seg && $past(w_irq, 2)
         && ($past(i_wdata, 2) == hbrg_pkg::HBRG_KEY_OPEN) |-> ##2
         $stable(i_base);
   endproperty
   a_low_zero: assert property (p_low_zero)
      else $error("base low bits set");
   a_strap: assert property (p_strap)
      else $error("strap base not loaded");
   a_cause: assert property (p_cause)
      else $error("base moved without confirm write");
   a_irq_clr: assert property (p_irq_clr)
      else $error("irq select kept on relocation");
   a_key_keep: assert property (p_key_keep)
      else $error("key write changed irq select");
   a_irq_set: assert property (p_irq_set)
      else $error("irq select not written");
   a_code: assert property (p_code)
      else $error("code access not granted");
   a_pulse: assert property (p_pulse)
      else $error("write strobe too long");
   a_first: assert property (p_first)
      else $error("first base write applied");
   // main scenarios seen
   c_reloc: cover property ((since_rst == 4'hF) && $changed(i_base));
   c_code: cover property (i_code_access);
   c_irq: cover property (w_irq && !key);
endmodule
`default_nettype wire

// *** host_base_relocation_guard_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module host_base_relocation_guard_tb_top;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] strap = 4'h3;
   logic [31:0] prdata, rd;
   logic pready, pslverr, hold, code, err;
   logic [7:0] irq, base;
   int n_mismatch = 0;
   int compares = 0;
   hbrg_if bus_if();
   hbrg_host i_hbrg_host(.I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
      .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .bus(bus_if.host));
   hbrg_dev i_hbrg_dev(.I_CLK(clk), .I_RST_B(rst_b), .bus(bus_if.dev),
      .I_SEGMENT_STRAP(strap), .O_CORE_HOLD(hold), .O_CODE_ACCESS(code),
      .O_IRQ_SEL(irq), .O_BASE(base));
   hbrg_monitor i_hbrg_monitor(.I_CLK(clk), .I_RST_B(rst_b),
      .i_addr(bus_if.addr), .i_wdata(bus_if.wdata), .i_wr(bus_if.wr),
      .i_strap(strap), .i_base(base), .i_irq_sel(irq),
      .i_code_access(code), .i_core_hold(hold));
   // free running 100 MHz clock
   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask
   // request held until pready is seen at a rising edge, then released
   // at that same edge; the next call waits an edge before its setup
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         n_mismatch++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // the controller has no completion strobe, so poll busy
   task automatic cmd(input logic [31:0] word);
      int n;
      apb(1'b1, hbrg_pkg::HBRG_APB_CMD, word);
      for (n = 0; n < 100; n++) begin
         apb(1'b0, hbrg_pkg::HBRG_APB_STAT, 32'h0);
         if (rd[8] === 1'b0) break;
      end
      if (n == 100) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask
   task automatic dw(input logic [13:0] ofs, input logic [7:0] d);
      cmd({3'b101, 7'h00, ofs, d});
   endtask
   task automatic do_reset(input logic [3:0] s);
      @(posedge clk);
      strap <= s;
      rst_b <= 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (10) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset(4'h3);
      check("strap base", base, hbrg_pkg::HBRG_STRAP_SEG[3]);
      check("core hold", hold, 32'h1);
      apb(1'b1, hbrg_pkg::HBRG_APB_STAT, {24'h0, 8'hD4});
      cmd({3'b110, 21'h0, 8'hA0});
      check("reloc base", base, 32'hA0);
      check("reloc irq", irq, 32'h0);
      check("code access", code, 32'h1);
      apb(1'b1, hbrg_pkg::HBRG_APB_STAT, {24'h0, 8'hA0});
      dw(14'h0001, 8'h05);
      check("irq select", irq, 32'h05);
      $display("test relocate done");
      dw(14'h0001, 8'h40);
      dw(14'h0002, 8'hB8);
      check("held base", base, 32'hA0);
      dw(14'h0000, 8'h00);
      dw(14'h0001, 8'h80);
      dw(14'h0002, 8'hB8);
      check("abandoned base", base, 32'hA0);
      check("keys keep irq", irq, 32'h05);
      dw(14'h0001, 8'h40);
      dw(14'h0002, 8'hB8);
      dw(14'h0002, 8'hB8);
      dw(14'h0001, 8'h80);
      dw(14'h0002, 8'hB8);
      check("repeat base", base, 32'hA0);
      $display("test abandon done");
      dw(14'h0001, 8'h40);
      dw(14'h0002, 8'hC4);
      dw(14'h0001, 8'h80);
      dw(14'h0002, 8'hC4);
      check("manual base", base, 32'hC4);
      check("manual irq", irq, 32'h0);
      apb(1'b1, hbrg_pkg::HBRG_APB_STAT, {24'h0, 8'hC4});
      cmd({3'b100, 7'h00, 14'h0002, 8'h00});
      apb(1'b0, hbrg_pkg::HBRG_APB_RDATA, 32'h0);
      check("base readback", rd, 32'hC4);
      apb(1'b0, 8'h0C, 32'h0);
      check("unmapped error", err, 32'h1);
      $display("test manual done");
      do_reset(4'hA);
      check("reset base", base, hbrg_pkg::HBRG_STRAP_SEG[10]);
      $display("test reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
